// ### cmp_pkg.sv
// constants and carrier types for the dual hysteresis comparator
// assumes a single 250 MHz clock domain and a classic wishbone register port
`default_nettype none

package cmp_pkg;

   // register byte offsets, index 0 is comparator 1, index 1 is comparator 2
   localparam logic [1:0][7:0] OFS_MODE   = {8'h0C, 8'h00};
   localparam logic [1:0][7:0] OFS_ON     = {8'h10, 8'h04};
   localparam logic [1:0][7:0] OFS_OFF    = {8'h14, 8'h08};
   localparam logic [7:0]      OFS_STATUS = 8'h18;

   // status register bit positions
   localparam int STAT_OUT1 = 0;
   localparam int STAT_OUT2 = 1;
   localparam int STAT_EXP  = 2;

   // thresholds in 0.01 percent steps
   localparam logic [15:0] THR_ON_RESET  = 16'h2710;  // 100.00 percent
   localparam logic [15:0] THR_OFF_RESET = 16'h1388;  // 50.00 percent
   localparam logic [15:0] THR_MAX       = 16'h7530;  // +300.00 percent
   localparam logic [15:0] THR_MIN       = 16'h8AD0;  // -300.00 percent
   localparam logic [15:0] PCT_FULL      = 16'h2710;  // 100.00 percent scale

   // fixed references in measurement counts
   localparam logic [15:0] TEMP_REF      = 16'h03E8;  // 100 degC at 0.1 degC
   localparam logic [15:0] DC_REF        = 16'h2710;  // 1000 V at 0.1 V
   localparam logic [15:0] AIN_FULL      = 16'h2710;  // full scale at 0.01 percent
   localparam logic [5:0]  SPEED_PER_FREQ = 6'h3C;    // 60 rpm per Hz and pole pair

   // mode codes
   localparam logic [7:0] MODE_OFF       = 8'h00;
   localparam logic [7:0] MODE_RMS_CUR   = 8'h01;
   localparam logic [7:0] MODE_ACT_CUR   = 8'h02;
   localparam logic [7:0] MODE_STAT_FREQ = 8'h03;
   localparam logic [7:0] MODE_ENC_SPEED = 8'h04;
   localparam logic [7:0] MODE_REP_FREQ  = 8'h05;
   localparam logic [7:0] MODE_WIND_TEMP = 8'h06;
   localparam logic [7:0] MODE_ACT_FREQ  = 8'h07;
   localparam logic [7:0] MODE_DC_VOLT   = 8'h09;
   localparam logic [7:0] MODE_ISQ       = 8'h0A;
   localparam logic [7:0] MODE_FILT_CUR  = 8'h0B;
   localparam logic [7:0] MODE_INT_REF   = 8'h0C;
   localparam logic [7:0] MODE_REF_PCT   = 8'h0D;
   localparam logic [7:0] MODE_ACT_PCT   = 8'h0E;
   localparam logic [7:0] MODE_AIN_ONE   = 8'h0F;
   localparam logic [7:0] SIGNED_FIRST   = 8'h64;     // 100
   localparam logic [7:0] SIGNED_LAST    = 8'h6B;     // 107

   // measured quantities from the drive, signed counts
   typedef struct packed {
      logic signed [15:0] rms_cur;
      logic signed [15:0] act_cur;
      logic signed [15:0] stator_freq;
      logic signed [15:0] enc_speed;
      logic signed [15:0] rep_freq;
      logic signed [15:0] wind_temp;
      logic signed [15:0] act_freq;
      logic signed [15:0] dc_volt;
      logic signed [15:0] isq;
      logic signed [15:0] filt_act_cur;
      logic signed [15:0] int_ref_freq;
      logic signed [15:0] ref_pct;
      logic signed [15:0] act_pct;
      logic signed [15:0] multifunction_analog_input_one;
   } meas_type;

   // reference quantities from the drive parameters
   typedef struct packed {
      logic [15:0] rated_cur;
      logic [15:0] max_freq;
      logic [15:0] max_ref_pct;
      logic [3:0]  pole_pairs;
   } refs_type;

   // result of one comparator evaluation
   typedef struct packed {
      logic valid;
      logic above;
      logic below;
   } eval_type;

   // all state of the block
   typedef struct packed {
      logic [1:0][7:0]  mode;
      logic [1:0][15:0] thr_on;
      logic [1:0][15:0] thr_off;
      logic [1:0]       outp;
      logic             exp_s1;
      logic             exp_s2;
      logic             ack;
      logic [31:0]      rdata;
   } state_type;

endpackage

`default_nettype wire

// ### dual_hysteresis_comparator.sv
// two hysteresis comparators with a classic wishbone register port
// assumes measured and reference inputs come from logic on clk_i
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`default_nettype none

module dual_hysteresis_comparator (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              expansion_present_i,
   input  wire cmp_pkg::meas_type meas_i,
   input  wire cmp_pkg::refs_type refs_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic [31:0]            dat_o,
   output logic                   ack_o,
   output logic [1:0]             cmp_o
);

   cmp_pkg::state_type state_r;
   cmp_pkg::state_type state_nxt;
   cmp_pkg::eval_type  ev [2];
   logic               req;

   // merge written byte lanes into a 16 bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sel);
      logic [15:0] res;
      begin
         res = old;
         if (sel[0]) res[7:0] = wd[7:0];
         if (sel[1]) res[15:8] = wd[15:8];
         return res;
      end
   endfunction

   // limit a written threshold to the legal percent range
   function automatic logic [15:0] clamp_thr(input logic signed [15:0] v);
      logic [15:0] res;
      begin
         res = v;
         if (v > $signed(cmp_pkg::THR_MAX)) res = cmp_pkg::THR_MAX;
         if (v < $signed(cmp_pkg::THR_MIN)) res = cmp_pkg::THR_MIN;
         return res;
      end
   endfunction

   // select quantity and reference, scale and compare against both thresholds
   function automatic cmp_pkg::eval_type cmp_eval(input logic [7:0]         mode,
                                                  input logic signed [15:0] thr_on,
                                                  input logic signed [15:0] thr_off,
                                                  input cmp_pkg::meas_type  m,
                                                  input cmp_pkg::refs_type  r,
                                                  input logic               exp_ok);
      cmp_pkg::eval_type  res;
      logic               sgn;
      logic [7:0]         base;
      logic signed [15:0] q;
      logic [15:0]        refv;
      logic [3:0]         knum;
      logic [5:0]         kden;
      logic signed [47:0] lhs;
      logic signed [47:0] on_t;
      logic signed [47:0] off_t;
      begin
         res   = '0;
         sgn   = (mode >= cmp_pkg::SIGNED_FIRST) && (mode <= cmp_pkg::SIGNED_LAST);
         base  = sgn ? mode - cmp_pkg::SIGNED_FIRST : mode;
         q     = '0;
         refv  = '0;
         knum  = 4'h1;
         kden  = 6'h01;
         res.valid = 1'b1;
         case (base)
            cmp_pkg::MODE_RMS_CUR: begin
               q    = m.rms_cur;
               refv = r.rated_cur;
            end
            cmp_pkg::MODE_ACT_CUR: begin
               q    = m.act_cur;
               refv = r.rated_cur;
            end
            cmp_pkg::MODE_ISQ: begin
               q    = m.isq;
               refv = r.rated_cur;
            end
            cmp_pkg::MODE_FILT_CUR: begin
               q    = m.filt_act_cur;
               refv = r.rated_cur;
            end
            cmp_pkg::MODE_STAT_FREQ: begin
               q    = m.stator_freq;
               refv = r.max_freq;
            end
            cmp_pkg::MODE_ENC_SPEED: begin
               q         = m.enc_speed;
               refv      = r.max_freq;
               knum      = r.pole_pairs;
               kden      = cmp_pkg::SPEED_PER_FREQ;
               res.valid = exp_ok && (r.pole_pairs != 4'h0);
            end
            cmp_pkg::MODE_REP_FREQ: begin
               q         = m.rep_freq;
               refv      = r.max_freq;
               res.valid = exp_ok;
            end
            cmp_pkg::MODE_ACT_FREQ: begin
               q    = m.act_freq;
               refv = r.max_freq;
            end
            cmp_pkg::MODE_INT_REF: begin
               q    = m.int_ref_freq;
               refv = r.max_freq;
            end
            cmp_pkg::MODE_REF_PCT: begin
               q    = m.ref_pct;
               refv = r.max_ref_pct;
            end
            cmp_pkg::MODE_ACT_PCT: begin
               q    = m.act_pct;
               refv = r.max_ref_pct;
            end
            cmp_pkg::MODE_WIND_TEMP: begin
               q    = m.wind_temp;
               refv = cmp_pkg::TEMP_REF;
            end
            cmp_pkg::MODE_DC_VOLT: begin
               q    = m.dc_volt;
               refv = cmp_pkg::DC_REF;
            end
            cmp_pkg::MODE_AIN_ONE: begin
               q    = m.multifunction_analog_input_one;
               refv = cmp_pkg::AIN_FULL;
            end
            default: res.valid = 1'b0;
         endcase
         lhs   = 48'(q);
         on_t  = 48'(thr_on);
         off_t = 48'(thr_off);
         // magnitude only, negative limits act as zero
         if (!sgn) begin
            if (lhs < 0) lhs = -lhs;
            if (on_t < 0) on_t = '0;
            if (off_t < 0) off_t = '0;
         end
         // q*100%*knum against thr*ref*kden avoids any divider; knum=pp and kden=60 in encoder speed mode, else 1
         lhs   = lhs * $signed(48'(cmp_pkg::PCT_FULL)) * $signed(48'(knum));
         on_t  = on_t * $signed(48'(refv)) * $signed(48'(kden));
         off_t = off_t * $signed(48'(refv)) * $signed(48'(kden));
         res.above = lhs > on_t;
         res.below = lhs < off_t;
         return res;
      end
   endfunction

   // evaluate both comparators from the current settings
   assign ev[0] = cmp_eval(state_r.mode[0], state_r.thr_on[0], state_r.thr_off[0],
                           meas_i, refs_i, state_r.exp_s2);
   assign ev[1] = cmp_eval(state_r.mode[1], state_r.thr_on[1], state_r.thr_off[1],
                           meas_i, refs_i, state_r.exp_s2);
   assign req   = cyc_i && stb_i;

   // next state: bus access, synchroniser, hysteresis
   always_comb begin
      state_nxt = state_r;
      if (ce_i) begin
         state_nxt.exp_s1 = expansion_present_i;
         state_nxt.exp_s2 = state_r.exp_s1;
         state_nxt.ack    = req && !state_r.ack;
         if (req && !state_r.ack) begin
            state_nxt.rdata = '0;
            for (int i = 0; i < 2; i++) begin
               if (adr_i == cmp_pkg::OFS_MODE[i]) begin
                  if (we_i && sel_i[0]) state_nxt.mode[i] = dat_i[7:0];
                  state_nxt.rdata[7:0] = state_r.mode[i];
               end
               if (adr_i == cmp_pkg::OFS_ON[i]) begin
                  if (we_i) state_nxt.thr_on[i] =
                     clamp_thr(merge16(state_r.thr_on[i], dat_i, sel_i));
                  state_nxt.rdata[15:0] = state_r.thr_on[i];
               end
               if (adr_i == cmp_pkg::OFS_OFF[i]) begin
                  if (we_i) state_nxt.thr_off[i] =
                     clamp_thr(merge16(state_r.thr_off[i], dat_i, sel_i));
                  state_nxt.rdata[15:0] = state_r.thr_off[i];
               end
            end
            if (adr_i == cmp_pkg::OFS_STATUS) begin
               state_nxt.rdata[cmp_pkg::STAT_OUT1] = state_r.outp[0];
               state_nxt.rdata[cmp_pkg::STAT_OUT2] = state_r.outp[1];
               state_nxt.rdata[cmp_pkg::STAT_EXP]  = state_r.exp_s2;
            end
         end
         // hysteresis per comparator, set has priority over clear
         for (int i = 0; i < 2; i++) begin
            if (state_nxt.mode[i] != state_r.mode[i] || !ev[i].valid) begin
               state_nxt.outp[i] = 1'b0;
            end else if (ev[i].above) begin
               state_nxt.outp[i] = 1'b1;
            end else if (ev[i].below) begin
               state_nxt.outp[i] = 1'b0;
            end
         end
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r         <= '0;
         state_r.thr_on  <= {2{cmp_pkg::THR_ON_RESET}};
         state_r.thr_off <= {2{cmp_pkg::THR_OFF_RESET}};
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from the state register
   assign dat_o = state_r.rdata;
   assign ack_o = state_r.ack;
   assign cmp_o = state_r.outp;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // checks on the comparator behaviour
   mode_off_low_a: assert property (
      (state_r.mode[0] == cmp_pkg::MODE_OFF) |-> !cmp_o[0])
      else $error("comparator 1 output high while off");
   set_above_a: assert property (
      (ce_i && ev[1].valid && ev[1].above && state_nxt.mode[1] == state_r.mode[1])
      |=> cmp_o[1])
      else $error("comparator 2 not set above on threshold");
   clear_below_a: assert property (
      (ce_i && ev[0].valid && !ev[0].above && ev[0].below) |=> !cmp_o[0])
      else $error("comparator 1 not cleared below off threshold");
   hold_between_a: assert property (
      (ce_i && ev[0].valid && !ev[0].above && !ev[0].below
       && state_nxt.mode[0] == state_r.mode[0]) |=> $stable(cmp_o[0]))
      else $error("comparator 1 output moved inside hysteresis band");
   mode_change_a: assert property (
      (ce_i && state_nxt.mode[1] != state_r.mode[1]) |=> !cmp_o[1])
      else $error("comparator 2 output not cleared on mode change");
   reset_values_a: assert property (
      $past(rst_i) |-> (state_r.thr_on[0] == cmp_pkg::THR_ON_RESET
                        && state_r.thr_off[1] == cmp_pkg::THR_OFF_RESET && cmp_o == 2'b00))
      else $error("wrong values after reset");
   thr_range_a: assert property (
      ($signed(state_r.thr_off[0]) <= $signed(cmp_pkg::THR_MAX))
      && ($signed(state_r.thr_off[0]) >= $signed(cmp_pkg::THR_MIN)))
      else $error("off threshold outside legal range");
   expansion_gate_a: assert property (
      (state_r.mode[1] == cmp_pkg::MODE_REP_FREQ && !state_r.exp_s2) |-> !ev[1].valid)
      else $error("expansion mode active without module");
   bus_ack_a: assert property (
      (ce_i && req && !ack_o) |=> ack_o ##1 (!ack_o || !ce_i))
      else $error("bus answer not a single cycle after request");
   freeze_a: assert property (
      !ce_i |=> $stable(state_r))
      else $error("state changed while clock enable low");

   // main scenarios
   set_seen_c: cover property (!cmp_o[0] ##1 cmp_o[0]);
   clear_seen_c: cover property (cmp_o[1] ##1 !cmp_o[1]);
   signed_set_c: cover property (
      (state_r.mode[0] >= cmp_pkg::SIGNED_FIRST) && cmp_o[0]);
   write_ack_c: cover property (req && we_i && ack_o);

endmodule

`default_nettype wire

// ### dual_hysteresis_comparator_bench.sv
// self-checking bench for the dual hysteresis comparator
// assumes the design files carry their own assertions; bench drives every port
`default_nettype none

module dual_hysteresis_comparator_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk_i;
   logic              rst_i;
   logic              ce_i;
   logic              expansion_present_i;
   cmp_pkg::meas_type meas_i;
   cmp_pkg::refs_type refs_i;
   logic              cyc_i;
   logic              stb_i;
   logic              we_i;
   logic [7:0]        adr_i;
   logic [3:0]        sel_i;
   logic [31:0]       dat_i;
   logic [31:0]       dat_o;
   logic              ack_o;
   logic [1:0]        cmp_o;
   logic [31:0]       exp_q[$];
   logic [31:0]       msk_q[$];
   logic [31:0]       lfsr_r;
   logic [15:0]       r;
   int                failures;
   int                tests_run;
   logic [7:0]        mode_tab[12] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h09,
                                       8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};

   dual_hysteresis_comparator dual_hysteresis_comparator_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .expansion_present_i(expansion_present_i),
      .meas_i(meas_i), .refs_i(refs_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .cmp_o(cmp_o));

   // free-running 250 MHz clock
   initial clk_i = 1'b0;
   always #2 clk_i = ~clk_i;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // reference in counts for the quantity a mode selects
   function automatic logic [15:0] ref_of(input logic [7:0] md);
      case (md)
         8'h06: return cmp_pkg::TEMP_REF;
         8'h09: return cmp_pkg::DC_REF;
         8'h0F: return cmp_pkg::AIN_FULL;
         default: return 16'h03E8;
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic results();
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // one classic cycle; notes what the answer should carry under a mask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] want, input logic [31:0] msk);
      int n;
      exp_q.push_back(want);
      msk_q.push_back(msk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1)
         failures++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask

   // random noise on all quantities, chosen one forced, then one edge to register it
   task automatic set_q(input logic [7:0] md, input logic [15:0] v);
      cmp_pkg::meas_type m;
      int                j;
      for (j = 0; j < 7; j++) begin
         lfsr_r = lfsr_next(lfsr_r);
         m[j*32 +: 32] = lfsr_r;
      end
      if (md >= 8'h64)
         md = md - 8'h64;
      case (md)
         8'h01: m.rms_cur = v;
         8'h02: m.act_cur = v;
         8'h03: m.stator_freq = v;
         8'h04: m.enc_speed = v;
         8'h05: m.rep_freq = v;
         8'h06: m.wind_temp = v;
         8'h07: m.act_freq = v;
         8'h09: m.dc_volt = v;
         8'h0A: m.isq = v;
         8'h0B: m.filt_act_cur = v;
         8'h0C: m.int_ref_freq = v;
         8'h0D: m.ref_pct = v;
         8'h0E: m.act_pct = v;
         default: m.multifunction_analog_input_one = v;
      endcase
      meas_i <= m;
      @(posedge clk_i);
   endtask

   // compares each bus answer, or cmp_o on a write, with the oldest note under its mask
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && exp_q.size() != 0) begin
         if (msk_q[0] != 32'h0000_0000)
            check((we_i ? {30'h0, cmp_o} : dat_o) & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      results();
   end

   // main sequence
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      expansion_present_i = 1'b0;
      meas_i = '0;
      refs_i = '{rated_cur: 16'h03E8, max_freq: 16'h03E8, max_ref_pct: 16'h03E8,
                 pole_pairs: 4'h2};
      {cyc_i, stb_i, we_i} = 3'h0;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0000_0000;
      lfsr_r = 32'ha915_2f4b;
      failures = 0;
      tests_run = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 2; i++) begin
         bus(1'b0, cmp_pkg::OFS_MODE[i], 0, 32'h0000_0000, '1);
         bus(1'b0, cmp_pkg::OFS_ON[i], 0, 32'h0000_2710, '1);
         bus(1'b0, cmp_pkg::OFS_OFF[i], 0, 32'h0000_1388, '1);
      end
      bus(1'b1, cmp_pkg::OFS_ON[0], 32'h0000_7531, 0, 0);
      bus(1'b0, cmp_pkg::OFS_ON[0], 0, 32'h0000_7530, '1);
      bus(1'b1, cmp_pkg::OFS_OFF[1], 32'h0000_8000, 0, 0);
      bus(1'b0, cmp_pkg::OFS_OFF[1], 0, 32'h0000_8AD0, '1);
      bus(1'b1, cmp_pkg::OFS_ON[0], 32'h0000_2710, 0, 0);
      bus(1'b1, cmp_pkg::OFS_OFF[1], 32'h0000_1388, 0, 0);
      bus(1'b0, 8'h1C, 0, 32'h0000_0000, '1);
      // every absolute mode except 04 and 05 on comparator 2: above, equal, negative above, below half
      foreach (mode_tab[k]) begin
         r = ref_of(mode_tab[k]);
         bus(1'b1, cmp_pkg::OFS_MODE[1], {24'h0, mode_tab[k]}, 0, 0);
         set_q(mode_tab[k], r + 16'h0001);
         bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0003);
         set_q(mode_tab[k], r);
         bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
         set_q(mode_tab[k], -(r + 16'h0001));
         bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
         set_q(mode_tab[k], (r >> 1) - 16'h0001 - (lfsr_r[15:0] % (r >> 2)));
         bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0002);
      end
      // mode change clears, signed mode keeps the sign
      bus(1'b1, cmp_pkg::OFS_MODE[0], 32'h0000_0001, 0, 0);
      set_q(8'h01, 16'h04B0);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0001, 32'h0000_0001);
      bus(1'b1, cmp_pkg::OFS_MODE[0], 32'h0000_0065, 0, 32'h0000_0001);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0001, 32'h0000_0001);
      set_q(8'h01, 16'hFB50);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0001);
      bus(1'b1, cmp_pkg::OFS_ON[0], 32'h0000_EC78, 0, 0);
      bus(1'b1, cmp_pkg::OFS_OFF[0], 32'h0000_E0C0, 0, 0);
      set_q(8'h01, 16'hFE70);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0001, 32'h0000_0001);
      set_q(8'h01, 16'hFD44);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0001, 32'h0000_0001);
      set_q(8'h01, 16'hFC7C);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0001);
      set_q(8'h01, 16'hFE70);
      bus(1'b1, cmp_pkg::OFS_MODE[0], 32'h0000_0000, 0, 0);
      bus(1'b1, cmp_pkg::OFS_STATUS, 32'h0000_FFFF, 0, 0);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0001);
      // expansion-only modes
      bus(1'b1, cmp_pkg::OFS_MODE[1], 32'h0000_0005, 0, 0);
      set_q(8'h05, 16'h03E9);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0006);
      expansion_present_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0006, 32'h0000_0006);
      bus(1'b1, cmp_pkg::OFS_MODE[1], 32'h0000_0004, 0, 0);
      set_q(8'h04, 16'h7531);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
      set_q(8'h04, 16'h7530);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
      set_q(8'h04, 16'h3A97);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0002);
      // clock enable low freezes the comparator state
      ce_i <= 1'b0;
      set_q(8'h04, 16'h7531);
      repeat (2) @(posedge clk_i);
      ce_i <= 1'b1;
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0000, 32'h0000_0002);
      bus(1'b0, cmp_pkg::OFS_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
      results();
   end

endmodule

`default_nettype wire
